/* hdl/fcs_host_ctrl.sv */
module fcs_host_ctrl (
  input  wire logic                   i_clk,
  input  wire logic                   i_nrst,
  input  wire logic [4:0]             i_reg_addr,
  input  wire logic [31:0]            i_reg_wdata,
  input  wire logic                   i_reg_wr,
  input  wire logic                   i_reg_rd,
  output logic [31:0]                 o_reg_rdata,
  output logic [fcs_pkg::AW-1:0]      o_flash_addr,
  output logic [7:0]                  o_dq_out,
  output logic                        o_dq_oe,
  input  wire logic [7:0]             i_dq_in,
  output logic                        o_chip_select_lower_n,
  output logic                        o_chip_select_upper_n,
  output logic                        o_we_n,
  output logic                        o_oe_n,
  input  wire logic                   i_ready_busy_n
);

  // ----------------------------------------------------------------
  // State.
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    FCS_IDLE, FCS_FETCH, FCS_LOAD, FCS_WSTART, FCS_WPULSE, FCS_WHOLD, FCS_RWAIT, FCS_SWAIT
  } fcs_state_type;

  typedef struct packed {
    fcs_state_type            st;       // Sequencer state.
    logic [3:0]               op;       // Operation in progress.
    logic                     upper;    // Upper chip select chosen.
    logic [2:0]               step;     // Cycle index within the sequence.
    logic [11:0]              cnt;      // Cycle timer.
    logic [fcs_pkg::AW-1:0]   addr;     // Software address register.
    logic [7:0]               wdata;    // Software program byte.
    logic [7:0]               rd_data;  // Last byte read.
    logic                     toggling; // Toggle bit moved between the two reads of a poll.
    logic                     tmo;      // Exceeded-time bit seen.
    logic                     busy;     // Operation in progress.
    logic [31:0]              bus_rd;   // Register read data.
    logic [fcs_pkg::AW-1:0]   pin_addr; // Address pins.
    logic [7:0]               dq_out;   // Data pins driven.
    logic                     dq_oe;    // Data pin enable.
    logic                     cs_lo_n;  // Lower chip select.
    logic                     cs_up_n;  // Upper chip select.
    logic                     we_n;     // Write strobe.
    logic                     oe_n;     // Output enable.
    logic [7:0]               dq_s1;    // Data synchroniser, first stage.
    logic [7:0]               dq_s2;    // Data synchroniser, second stage.
    logic                     rb_s1;    // Ready/busy synchroniser, first stage.
    logic                     rb_s2;    // Ready/busy synchroniser, second stage.
  } fcs_regs_type;

  fcs_regs_type             s_q;        // Registered state.
  fcs_regs_type             s_d;        // Next state.
  logic [fcs_pkg::E_W-1:0]  entry;      // Current step description.

  // ----------------------------------------------------------------
  // Sequence table.
  // ----------------------------------------------------------------
  fcs_seq_rom u_rom (
    .i_clk   (i_clk),
    .i_nrst  (i_nrst),
    .i_op    (s_q.op),
    .i_step  (s_q.step),
    .o_entry (entry)
  );

  // Ends one bus cycle: next step, suspend wait, or back to idle.
  function automatic fcs_regs_type step_done(input fcs_regs_type x, input logic last);
    step_done = x;
    if (!last) begin
      step_done.step = 3'(x.step + 3'd1);
      step_done.st   = FCS_FETCH;
    end else if (x.op == fcs_pkg::OP_SUSPEND) begin
      // The device may need this long to stop an active erase.
      step_done.cnt  = 12'(fcs_pkg::SUSP_CYC - 12'd1);
      step_done.st   = FCS_SWAIT;
    end else begin
      step_done.busy = 1'b0;
      step_done.st   = FCS_IDLE;
    end
  endfunction : step_done

  // ----------------------------------------------------------------
  // Next-state logic.
  // ----------------------------------------------------------------
  always_comb begin
    s_d        = s_q;
    s_d.dq_s1  = i_dq_in;
    s_d.dq_s2  = s_q.dq_s1;
    s_d.rb_s1  = i_ready_busy_n;
    s_d.rb_s2  = s_q.rb_s1;
    s_d.bus_rd = '0;

    // Register reads answer one cycle later; unmapped offsets read zero.
    if (i_reg_rd) begin
      unique case (i_reg_addr)
        fcs_pkg::REG_CMD:    s_d.bus_rd = {27'h0, s_q.upper, s_q.op};
        fcs_pkg::REG_ADDR:   s_d.bus_rd = {9'h0, s_q.addr};
        fcs_pkg::REG_WDATA:  s_d.bus_rd = {24'h0, s_q.wdata};
        fcs_pkg::REG_STATUS: s_d.bus_rd = {28'h0, s_q.tmo, s_q.toggling, s_q.rb_s2, s_q.busy};
        fcs_pkg::REG_RDATA:  s_d.bus_rd = {24'h0, s_q.rd_data};
        default:             s_d.bus_rd = '0;
      endcase
    end

    // Register writes; a start while busy is dropped.
    if (i_reg_wr) begin
      if (i_reg_addr == fcs_pkg::REG_ADDR) begin
        s_d.addr = i_reg_wdata[fcs_pkg::AW-1:0];
      end
      if (i_reg_addr == fcs_pkg::REG_WDATA) begin
        s_d.wdata = i_reg_wdata[7:0];
      end
      if (i_reg_addr == fcs_pkg::REG_CMD && !s_q.busy) begin
        s_d.op    = i_reg_wdata[fcs_pkg::CMD_OP_LSB +: 4];
        s_d.upper = i_reg_wdata[fcs_pkg::CMD_UPPER];
        s_d.step  = 3'd0;
        s_d.busy  = 1'b1;
        s_d.st    = FCS_FETCH;
      end
    end

    unique case (s_q.st)
      FCS_IDLE: begin
        // Waiting for software.
      end
      FCS_FETCH: begin
        // The table answers one cycle after the step changes.
        s_d.st = FCS_LOAD;
      end
      FCS_LOAD: begin
        // Address and chip select settle before the write strobe moves; a read drops output enable with them.
        s_d.pin_addr = entry[fcs_pkg::E_ADDR] ? s_q.addr : '0;
        s_d.cs_lo_n  = s_q.upper;
        s_d.cs_up_n  = !s_q.upper;
        if (entry[fcs_pkg::E_RD]) begin
          s_d.dq_oe = 1'b0;
          s_d.oe_n  = 1'b0;
          s_d.cnt   = 12'(fcs_pkg::ACC_CYC - 12'd1);
          s_d.st    = FCS_RWAIT;
        end else begin
          s_d.dq_out = entry[fcs_pkg::E_WDAT] ? s_q.wdata : entry[7:0];
          s_d.dq_oe  = 1'b1;
          s_d.st     = FCS_WSTART;
        end
      end
      FCS_WSTART: begin
        // Write strobe falls last, so the device latches a stable address.
        s_d.we_n = 1'b0;
        s_d.cnt  = 12'(fcs_pkg::WP_CYC - 12'd1);
        s_d.st   = FCS_WPULSE;
      end
      FCS_WPULSE: begin
        if (s_q.cnt == 12'd0) begin
          // Write strobe rises first; data stays driven past it.
          s_d.we_n = 1'b1;
          s_d.cnt  = 12'(fcs_pkg::WPH_CYC - 12'd1);
          s_d.st   = FCS_WHOLD;
        end else begin
          s_d.cnt = 12'(s_q.cnt - 12'd1);
        end
      end
      FCS_WHOLD: begin
        if (s_q.cnt == 12'd0) begin
          s_d.cs_lo_n = 1'b1;
          s_d.cs_up_n = 1'b1;
          s_d.dq_oe   = 1'b0;
          s_d         = step_done(s_d, entry[fcs_pkg::E_LAST]);
        end else begin
          s_d.cnt = 12'(s_q.cnt - 12'd1);
        end
      end
      FCS_RWAIT: begin
        // Count covers access time plus the synchroniser delay.
        if (s_q.cnt == 12'd0) begin
          s_d.rd_data = s_q.dq_s2;
          s_d.oe_n    = 1'b1;
          s_d.cs_lo_n = 1'b1;
          s_d.cs_up_n = 1'b1;
          if (s_q.op == fcs_pkg::OP_POLL && entry[fcs_pkg::E_LAST]) begin
            // Two reads in a row: a moving toggle bit means still busy.
            s_d.toggling = s_q.dq_s2[6] ^ s_q.rd_data[6];
            s_d.tmo      = s_q.dq_s2[5];
          end
          s_d = step_done(s_d, entry[fcs_pkg::E_LAST]);
        end else begin
          s_d.cnt = 12'(s_q.cnt - 12'd1);
        end
      end
      FCS_SWAIT: begin
        if (s_q.cnt == 12'd0) begin
          s_d.busy = 1'b0;
          s_d.st   = FCS_IDLE;
        end else begin
          s_d.cnt = 12'(s_q.cnt - 12'd1);
        end
      end
    endcase
  end

  // ----------------------------------------------------------------
  // State register; strobes and selects idle high.
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      s_q         <= '0;
      s_q.cs_lo_n <= 1'b1;
      s_q.cs_up_n <= 1'b1;
      s_q.we_n    <= 1'b1;
      s_q.oe_n    <= 1'b1;
      s_q.rb_s1   <= 1'b1;
      s_q.rb_s2   <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign o_reg_rdata           = s_q.bus_rd;
  assign o_flash_addr          = s_q.pin_addr;
  assign o_dq_out              = s_q.dq_out;
  assign o_dq_oe               = s_q.dq_oe;
  assign o_chip_select_lower_n = s_q.cs_lo_n;
  assign o_chip_select_upper_n = s_q.cs_up_n;
  assign o_we_n                = s_q.we_n;
  assign o_oe_n                = s_q.oe_n;

  // ----------------------------------------------------------------
  // Checks.
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_nrst);

  property p_we_width;
    $fell(o_we_n) |-> !o_we_n [*4] ##1 o_we_n ##1 o_we_n [*2];
  endproperty
  a_we_width: assert property (p_we_width) else $error("write pulse width wrong");

  property p_we_stable;
    !o_we_n && !$past(o_we_n) |-> $stable(o_dq_out) && $stable(o_flash_addr) && o_dq_oe;
  endproperty
  a_we_stable: assert property (p_we_stable) else $error("pins moved in pulse");

  property p_suspend_byte;
    $fell(o_we_n) && s_q.op == fcs_pkg::OP_SUSPEND |-> o_dq_out == 8'hb0
      && o_flash_addr == s_q.addr;
  endproperty
  a_suspend_byte: assert property (p_suspend_byte) else $error("bad suspend write");

  property p_resume_byte;
    $fell(o_we_n) && s_q.op == fcs_pkg::OP_RESUME |-> o_dq_out == 8'h30
      && o_flash_addr == s_q.addr;
  endproperty
  a_resume_byte: assert property (p_resume_byte) else $error("bad resume write");

  property p_reset_byte;
    $fell(o_we_n) && s_q.op == fcs_pkg::OP_RESET |-> o_dq_out == 8'hf0;
  endproperty
  a_reset_byte: assert property (p_reset_byte) else $error("bad reset write");

  property p_ident_read;
    $fell(o_oe_n) && s_q.op == fcs_pkg::OP_IDENT |-> s_q.step == 3'd3;
  endproperty
  a_ident_read: assert property (p_ident_read) else $error("ident read early");

  property p_prog_data;
    $fell(o_we_n) && s_q.op == fcs_pkg::OP_PROG && s_q.step == 3'd3
      |-> o_dq_out == s_q.wdata && o_flash_addr == s_q.addr;
  endproperty
  a_prog_data: assert property (p_prog_data) else $error("bad program write");

  property p_bypass_entry;
    $fell(o_we_n) && s_q.op == fcs_pkg::OP_BYP_IN && s_q.step == 3'd2 |-> o_dq_out == 8'h20;
  endproperty
  a_bypass_entry: assert property (p_bypass_entry) else $error("bad bypass entry");

  property p_bypass_exit;
    $fell(o_we_n) && s_q.op == fcs_pkg::OP_BYP_OUT
      |-> o_dq_out == ((s_q.step == 3'd0) ? 8'h90 : 8'h00);
  endproperty
  a_bypass_exit: assert property (p_bypass_exit) else $error("bad bypass exit");

  property p_no_contention;
    !(o_dq_oe && !o_oe_n) && !(!o_we_n && !o_oe_n);
  endproperty
  a_no_contention: assert property (p_no_contention) else $error("bus contention");

  property p_suspend_wait;
    s_q.op == fcs_pkg::OP_SUSPEND && $rose(o_chip_select_lower_n && o_chip_select_upper_n)
      |-> s_q.busy [*8];
  endproperty
  a_suspend_wait: assert property (p_suspend_wait) else $error("suspend wait short");

endmodule : fcs_host_ctrl

/* hdl/fcs_pkg.sv */
package fcs_pkg;

  // ----------------------------------------------------------------
  // Clock and timing.
  // ----------------------------------------------------------------
  localparam int unsigned CLK_NS      = 10;    // Clock period in ns.
  localparam int unsigned T_WP_NS     = 35;    // Least write pulse width.
  localparam int unsigned T_WPH_NS    = 30;    // Least write pulse high time.
  localparam int unsigned T_ACC_NS    = 90;    // Read access time.
  localparam int unsigned T_SUSP_US   = 20;    // Longest suspend latency.
  localparam int unsigned SYNC_STAGES = 2;     // Pin synchroniser depth.

  // Least times round up to whole cycles.
  localparam logic [11:0] WP_CYC   = 12'((T_WP_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [11:0] WPH_CYC  = 12'((T_WPH_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [11:0] ACC_CYC  = 12'((T_ACC_NS + CLK_NS - 1) / CLK_NS + SYNC_STAGES);
  localparam logic [11:0] SUSP_CYC = 12'((T_SUSP_US * 1000 + CLK_NS - 1) / CLK_NS);

  // ----------------------------------------------------------------
  // Register map of the controller, byte addresses.
  // ----------------------------------------------------------------
  localparam logic [4:0] REG_CMD    = 5'h00;  // Start an operation, read back op.
  localparam logic [4:0] REG_ADDR   = 5'h04;  // Target, sector or bank address.
  localparam logic [4:0] REG_WDATA  = 5'h08;  // Byte to program.
  localparam logic [4:0] REG_STATUS = 5'h0c;  // Controller and flash status.
  localparam logic [4:0] REG_RDATA  = 5'h10;  // Last byte read from flash.

  localparam int unsigned CMD_OP_LSB = 0;     // Operation code field.
  localparam int unsigned CMD_UPPER  = 4;     // Selects the upper chip select.
  localparam int unsigned ST_BUSY    = 0;     // Operation in progress.
  localparam int unsigned ST_RDY     = 1;     // Synchronised ready/busy level.
  localparam int unsigned ST_TOGGLE  = 2;     // Toggle bit moved in last poll.
  localparam int unsigned ST_TMO     = 3;     // Exceeded-time bit seen in poll.

  // ----------------------------------------------------------------
  // Operations that software may start.
  // ----------------------------------------------------------------
  localparam logic [3:0] OP_READ    = 4'h0;
  localparam logic [3:0] OP_RESET   = 4'h1;
  localparam logic [3:0] OP_IDENT   = 4'h2;
  localparam logic [3:0] OP_PROG    = 4'h3;
  localparam logic [3:0] OP_BYP_IN  = 4'h4;
  localparam logic [3:0] OP_BYP_PRG = 4'h5;
  localparam logic [3:0] OP_BYP_OUT = 4'h6;
  localparam logic [3:0] OP_CHIP_ER = 4'h7;
  localparam logic [3:0] OP_SECT_ER = 4'h8;
  localparam logic [3:0] OP_SUSPEND = 4'h9;
  localparam logic [3:0] OP_RESUME  = 4'ha;
  localparam logic [3:0] OP_QUERY   = 4'hb;
  localparam logic [3:0] OP_POLL    = 4'hc;

  // ----------------------------------------------------------------
  // Command bytes on the flash data lines.
  // ----------------------------------------------------------------
  localparam logic [7:0] CB_UNLOCK1 = 8'haa;
  localparam logic [7:0] CB_UNLOCK2 = 8'h55;
  localparam logic [7:0] CB_IDENT   = 8'h90;  // Also first byte of bypass exit.
  localparam logic [7:0] CB_PROG    = 8'ha0;
  localparam logic [7:0] CB_BYPASS  = 8'h20;
  localparam logic [7:0] CB_BYP_END = 8'h00;
  localparam logic [7:0] CB_ER_SET  = 8'h80;
  localparam logic [7:0] CB_CHIP    = 8'h10;
  localparam logic [7:0] CB_SECTOR  = 8'h30;  // Also the resume byte.
  localparam logic [7:0] CB_SUSPEND = 8'hb0;
  localparam logic [7:0] CB_RESET   = 8'hf0;
  localparam logic [7:0] CB_QUERY   = 8'h98;
  localparam logic [7:0] CB_NONE    = 8'h00;

  // ----------------------------------------------------------------
  // Sequence step entry layout.
  // ----------------------------------------------------------------
  localparam int unsigned E_LAST = 11;        // Final cycle of the sequence.
  localparam int unsigned E_RD   = 10;        // Cycle is a read.
  localparam int unsigned E_ADDR = 9;         // Drive the target address.
  localparam int unsigned E_WDAT = 8;         // Drive the program byte.
  localparam int unsigned E_W    = 12;        // Entry width.

  localparam int unsigned AW = 23;            // Flash address width.

endpackage : fcs_pkg

/* hdl/fcs_seq_rom.sv */
module fcs_seq_rom (
  input  wire logic                  i_clk,
  input  wire logic                  i_nrst,
  input  wire logic [3:0]            i_op,
  input  wire logic [2:0]            i_step,
  output logic [fcs_pkg::E_W-1:0]    o_entry
);

  // ----------------------------------------------------------------
  // Entry builders.
  // ----------------------------------------------------------------

  // Packs one bus cycle description.
  function automatic logic [fcs_pkg::E_W-1:0] ent(input logic last, input logic rd,
                                                   input logic ua, input logic uw,
                                                   input logic [7:0] data);
    ent = {last, rd, ua, uw, data};
  endfunction : ent

  // The two unlock writes followed by a command byte at step two.
  function automatic logic [fcs_pkg::E_W-1:0] unl(input logic [2:0] step,
                                                   input logic [7:0] cmd,
                                                   input logic last);
    unique case (step)
      3'd0:    unl = ent(1'b0, 1'b0, 1'b0, 1'b0, fcs_pkg::CB_UNLOCK1);
      3'd1:    unl = ent(1'b0, 1'b0, 1'b0, 1'b0, fcs_pkg::CB_UNLOCK2);
      default: unl = ent(last, 1'b0, 1'b0, 1'b0, cmd);
    endcase
  endfunction : unl

  logic [fcs_pkg::E_W-1:0] entry_d;  // Combinational lookup.

  // ----------------------------------------------------------------
  // Lookup of each operation's cycle list.
  // ----------------------------------------------------------------
  always_comb begin
    unique case (i_op)
      fcs_pkg::OP_RESET:   entry_d = ent(1'b1, 1'b0, 1'b0, 1'b0, fcs_pkg::CB_RESET);
      fcs_pkg::OP_IDENT:   entry_d = (i_step == 3'd3) ?
                                     ent(1'b1, 1'b1, 1'b1, 1'b0, fcs_pkg::CB_NONE) :
                                     unl(i_step, fcs_pkg::CB_IDENT, 1'b0);
      fcs_pkg::OP_PROG:    entry_d = (i_step == 3'd3) ?
                                     ent(1'b1, 1'b0, 1'b1, 1'b1, fcs_pkg::CB_NONE) :
                                     unl(i_step, fcs_pkg::CB_PROG, 1'b0);
      fcs_pkg::OP_BYP_IN:  entry_d = unl(i_step, fcs_pkg::CB_BYPASS, 1'b1);
      fcs_pkg::OP_BYP_PRG: entry_d = (i_step == 3'd0) ?
                                     ent(1'b0, 1'b0, 1'b0, 1'b0, fcs_pkg::CB_PROG) :
                                     ent(1'b1, 1'b0, 1'b1, 1'b1, fcs_pkg::CB_NONE);
      fcs_pkg::OP_BYP_OUT: entry_d = (i_step == 3'd0) ?
                                     ent(1'b0, 1'b0, 1'b0, 1'b0, fcs_pkg::CB_IDENT) :
                                     ent(1'b1, 1'b0, 1'b0, 1'b0, fcs_pkg::CB_BYP_END);
      fcs_pkg::OP_CHIP_ER: entry_d = (i_step == 3'd5) ?
                                     ent(1'b1, 1'b0, 1'b0, 1'b0, fcs_pkg::CB_CHIP) :
                                     unl((i_step > 3'd2) ? 3'(i_step - 3'd3) : i_step,
                                         fcs_pkg::CB_ER_SET, 1'b0);
      fcs_pkg::OP_SECT_ER: entry_d = (i_step == 3'd5) ?
                                     ent(1'b1, 1'b0, 1'b1, 1'b0, fcs_pkg::CB_SECTOR) :
                                     unl((i_step > 3'd2) ? 3'(i_step - 3'd3) : i_step,
                                         fcs_pkg::CB_ER_SET, 1'b0);
      fcs_pkg::OP_SUSPEND: entry_d = ent(1'b1, 1'b0, 1'b1, 1'b0, fcs_pkg::CB_SUSPEND);
      fcs_pkg::OP_RESUME:  entry_d = ent(1'b1, 1'b0, 1'b1, 1'b0, fcs_pkg::CB_SECTOR);
      fcs_pkg::OP_QUERY:   entry_d = ent(1'b1, 1'b0, 1'b0, 1'b0, fcs_pkg::CB_QUERY);
      fcs_pkg::OP_POLL:    entry_d = ent(i_step != 3'd0, 1'b1, 1'b1, 1'b0, fcs_pkg::CB_NONE);
      // Plain reads and unknown codes fall back to a single array read.
      default:             entry_d = ent(1'b1, 1'b1, 1'b1, 1'b0, fcs_pkg::CB_NONE);
    endcase
  end

  // ----------------------------------------------------------------
  // Registered read data.
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_entry <= '0;
    end else begin
      o_entry <= entry_d;
    end
  end

endmodule : fcs_seq_rom

/* verification/fcs_flash_model.sv */
// Behavioural flash device on the far side of the controller.
module fcs_flash_model #(
  parameter logic [7:0] MAKER = 8'h4d,  // Arbitrary value.
  parameter logic [7:0] PART  = 8'h62   // Arbitrary value.
) (
  input  wire logic [22:0] i_addr,
  input  wire logic [7:0]  i_dq,
  input  wire logic        i_cs_lo_n,
  input  wire logic        i_cs_hi_n,
  input  wire logic        i_we_n,
  input  wire logic        i_oe_n,
  output logic [7:0]       o_dq,
  output logic             o_rdy_n
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0]  mem [256];
  logic [7:0]  wlog [$];  // Every byte written, for the bench.
  logic [22:0] a_q;
  logic [7:0]  last = 8'h00, held = 8'h00, val;
  logic [1:0]  st = 2'd0, mode = 2'd0;
  logic        armed = 1'b0, tog = 1'b0, wpend = 1'b0;
  logic        er = 1'b0, ers = 1'b0, susp = 1'b0;  // Erase set-up, sector erasing, suspended.
  logic [6:0]  esec = 7'h00;  // Sector under erase.
  realtime     busy_end = 0, rem = 0;
  wire         csn = i_cs_lo_n & i_cs_hi_n;
  wire         busy = !o_rdy_n;
  initial foreach (mem[i]) mem[i] = 8'hff;
  always #5 begin
    o_rdy_n = ($realtime >= busy_end);
    if (o_rdy_n && !susp) ers = 1'b0;
  end
  // Only a real falling strobe arms a write, so leaving reset is none.
  always @(negedge (csn | i_we_n)) begin
    a_q = i_addr;
    wpend = 1'b1;
  end
  // Commands act on the data latched at the end of the pulse.
  always @(posedge (csn | i_we_n)) if (wpend) begin
    wpend = 1'b0;
    wlog.push_back(i_dq);
    if (busy && ers && !susp && i_dq == 8'hb0) begin
      rem = busy_end - $realtime;
      busy_end = $realtime + 5000;
      susp = 1'b1;
    end else if (!busy && armed) begin
      mem[a_q[7:0]] = i_dq;
      last = i_dq;
      armed = 1'b0;
      busy_end = $realtime + 2000;
    end else if (!busy) begin
      if (susp && st == 0 && i_dq == 8'h30 && a_q[22:16] == esec) begin
        susp = 1'b0;
        busy_end = $realtime + rem;
      end
      if (st == 2 && er && i_dq == 8'h30) begin
        ers = 1'b1;
        esec = a_q[22:16];
        busy_end = $realtime + 100000;
      end
      if (st == 2 && er && i_dq == 8'h10) busy_end = $realtime + 30000;
      if (st == 2) er = i_dq == 8'h80;
      armed = (mode == 2 || st == 2) && i_dq == 8'ha0;
      if (i_dq == 8'hf0) mode = 0;
      if (st == 0 && i_dq == 8'h98 && mode != 2) mode = 3;
      if (st == 2 && i_dq == 8'h90) mode = 1;
      if (st == 2 && i_dq == 8'h20) mode = 2;
      if (st == 3 && i_dq == 8'h00) mode = 0;
      st = (i_dq == 8'haa && st == 0) ? 2'd1 : (i_dq == 8'h55 && st == 1) ? 2'd2 :
           (mode == 2 && i_dq == 8'h90) ? 2'd3 : 2'd0;
    end
  end
  always @(negedge (csn | i_oe_n)) if (busy) tog = ~tog;
  always_comb begin
    if (busy) val = {~last[7], tog, 6'h00};
    else if (mode == 1) val = (i_addr[1:0] == 0) ? MAKER : (i_addr[1:0] == 1) ? PART : 8'h00;
    else if (mode == 3) val = 8'hc3;
    else if (susp && i_addr[22:16] == esec) val = {1'b1, tog, 6'h00};
    else val = mem[i_addr[7:0]];
  end
  // Released lines show the inverse so a stale sample cannot pass.
  always @(posedge (csn | i_oe_n)) held = val;
  assign o_dq = (csn | i_oe_n) ? ~held : val;
endmodule : fcs_flash_model

/* verification/fcs_host_ctrl_tb.sv */
module fcs_host_ctrl_tb;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct {logic [3:0] op; logic [22:0] a; logic [7:0] d; logic [31:0] e;} fcs_row_type;
  logic        clk = 0, nrst = 0, wr = 0, rd = 0;
  logic [4:0]  ra = 0;
  logic [31:0] wd = 0, q;
  wire  [31:0] rdat;
  wire  [22:0] fa;
  wire  [7:0]  dqo, dqd;
  wire         oe_en, csl, csh, wen, oen, rbn;
  wire  [7:0]  dq = oe_en ? dqo : dqd;
  int          miscompares = 0, tests_run = 0;
  fcs_row_type rows [13] = '{
    '{4'h3, 23'h5, 8'h6e, 32'h6e}, '{4'h0, 23'h5, 8'h00, 32'h6e},
    '{4'h2, 23'h0, 8'h00, 32'h4d}, '{4'h2, 23'h1, 8'h00, 32'h62},
    '{4'h2, 23'h30002, 8'h00, 32'h00}, '{4'h1, 23'h0, 8'h00, 32'hf0},
    '{4'h4, 23'h0, 8'h00, 32'h20}, '{4'h5, 23'h6, 8'ha5, 32'ha5},
    '{4'h6, 23'h0, 8'h00, 32'h00}, '{4'h0, 23'h6, 8'h00, 32'ha5},
    '{4'hb, 23'h0, 8'h00, 32'h98}, '{4'h0, 23'h0, 8'h00, 32'hc3},
    '{4'h1, 23'h0, 8'h00, 32'hf0}};
  always #5 clk = ~clk;
  fcs_host_ctrl uut (.i_clk(clk), .i_nrst(nrst), .i_reg_addr(ra), .i_reg_wdata(wd),
    .i_reg_wr(wr), .i_reg_rd(rd), .o_reg_rdata(rdat), .o_flash_addr(fa), .o_dq_out(dqo),
    .o_dq_oe(oe_en), .i_dq_in(dq), .o_chip_select_lower_n(csl), .o_chip_select_upper_n(csh),
    .o_we_n(wen), .o_oe_n(oen), .i_ready_busy_n(rbn));
  fcs_flash_model dev (.i_addr(fa), .i_dq(dq), .i_cs_lo_n(csl), .i_cs_hi_n(csh),
    .i_we_n(wen), .i_oe_n(oen), .o_dq(dqd), .o_rdy_n(rbn));
  task automatic chk(string n, logic [31:0] s, logic [31:0] e);
    tests_run++;
    if (s !== e) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic wreg(logic [4:0] a, logic [31:0] d);
    ra <= a;
    wd <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask : wreg
  // Read data stand only in the cycle after the strobe.
  task automatic rreg(logic [4:0] a, output logic [31:0] s);
    ra <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 s = rdat;
    @(posedge clk);
  endtask : rreg
  // Start an op; wait for the controller, and for the device too if w.
  task automatic run(logic [3:0] op, logic [22:0] a, logic [7:0] d, bit w);
    logic [31:0] s;
    wreg(fcs_pkg::REG_ADDR, 32'(a));
    wreg(fcs_pkg::REG_WDATA, 32'(d));
    wreg(fcs_pkg::REG_CMD, 32'(op));
    s = 32'h1;
    for (int i = 0; i < 3000 && (s[0] || (w && !s[1])); i++) rreg(fcs_pkg::REG_STATUS, s);
    chk("op done", 32'(s[0] || (w && !s[1])), 32'h0);
  endtask : run
  task automatic stop_test();
    $display("Comparisons %0d, mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : stop_test
  // Whole run is well under 200 us; a hang is cut off at 400 us.
  initial begin
    #400us;
    miscompares++;
    stop_test();
  end
  initial begin
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    rreg(fcs_pkg::REG_STATUS, q);
    chk("idle status", q, 32'h2);
    rreg(5'h14, q);
    chk("unmapped", q, 32'h0);
    foreach (rows[i]) begin
      run(rows[i].op, rows[i].a, rows[i].d, 1'b1);
      if (rows[i].op inside {4'h0, 4'h2}) rreg(fcs_pkg::REG_RDATA, q);
      else q = 32'(dev.wlog[$]);
      chk("row", q, rows[i].e);
    end
    // Poll while the program runs, then again once it is done.
    run(fcs_pkg::OP_PROG, 23'h7, 8'h81, 1'b0);
    run(fcs_pkg::OP_POLL, 23'h7, 8'h00, 1'b0);
    rreg(fcs_pkg::REG_STATUS, q);
    chk("busy poll", q & 32'h6, 32'h4);
    rreg(fcs_pkg::REG_RDATA, q);
    chk("poll bit", q & 32'h80, 32'h0);
    run(fcs_pkg::OP_SUSPEND, 23'h7, 8'h00, 1'b1);
    chk("suspend byte", 32'(dev.wlog[$]), 32'hb0);
    run(fcs_pkg::OP_POLL, 23'h7, 8'h00, 1'b1);
    rreg(fcs_pkg::REG_STATUS, q);
    chk("done poll", q & 32'h4, 32'h0);
    rreg(fcs_pkg::REG_RDATA, q);
    chk("done data", q, 32'h81);
    // Suspend is ignored in a chip erase and honoured in a sector erase.
    run(fcs_pkg::OP_CHIP_ER, 23'h0, 8'h00, 1'b0);
    run(fcs_pkg::OP_SUSPEND, 23'h0, 8'h00, 1'b0);
    rreg(fcs_pkg::REG_STATUS, q);
    chk("chip erase busy", q & 32'h2, 32'h0);
    run(fcs_pkg::OP_POLL, 23'h0, 8'h00, 1'b1);
    run(fcs_pkg::OP_SECT_ER, 23'h10000, 8'h00, 1'b0);
    run(fcs_pkg::OP_SUSPEND, 23'h10000, 8'h00, 1'b0);
    rreg(fcs_pkg::REG_STATUS, q);
    chk("suspended ready", q & 32'h2, 32'h2);
    run(fcs_pkg::OP_PROG, 23'h9, 8'h3c, 1'b1);
    run(fcs_pkg::OP_READ, 23'h9, 8'h00, 1'b1);
    rreg(fcs_pkg::REG_RDATA, q);
    chk("suspend program", q, 32'h3c);
    run(fcs_pkg::OP_IDENT, 23'h0, 8'h00, 1'b1);
    rreg(fcs_pkg::REG_RDATA, q);
    chk("suspend ident", q, 32'h4d);
    run(fcs_pkg::OP_RESET, 23'h0, 8'h00, 1'b1);
    run(fcs_pkg::OP_POLL, 23'h10004, 8'h00, 1'b1);
    rreg(fcs_pkg::REG_RDATA, q);
    chk("suspended sector", q & 32'h80, 32'h80);
    rreg(fcs_pkg::REG_STATUS, q);
    chk("suspend toggle", q & 32'h4, 32'h0);
    run(fcs_pkg::OP_RESUME, 23'h10000, 8'h00, 1'b0);
    rreg(fcs_pkg::REG_STATUS, q);
    chk("resumed", q & 32'h2, 32'h0);
    stop_test();
  end
endmodule : fcs_host_ctrl_tb
